//--- ubd_top.sv
`timescale 1ns/100ps

module ubd_top import ubd_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic DP_I,
    input wire logic DM_I,
    output logic DP_O,
    output logic DP_OE,
    output logic DM_O,
    output logic DM_OE,
    output logic DP_PULLUP_EN,
    output logic DP_PULLDN_EN,
    output logic DM_PULLDN_EN,
    input wire logic TOKEN_VALID,
    input wire logic [3:0] TOKEN_EP,
    input wire logic TOKEN_DIR,
    input wire logic TOKEN_SETUP,
    input wire logic XFER_DONE,
    input wire logic [3:0] XFER_EP,
    input wire logic XFER_DIR,
    input wire logic [3:0] XFER_SRC_EP,
    output logic DESC_VALID,
    output logic [5:0] DESC_INDEX,
    output logic [15:0] DESC_STAT_ADDR,
    output logic [15:0] DESC_BUF_ADDR,
    output logic ENGINE_HALT,
    output logic HOST_TOKEN_STB,
    output logic [3:0] HOST_TOKEN_PID,
    output logic [3:0] HOST_DEST_EP,
    output logic IRQ
);

    // ==========================================================
    // register state
    logic usb_module_enable_q, usb_module_enable_d;
    logic pingpong_pointer_reset_q, pingpong_pointer_reset_d;
    logic resume_q, resume_d;
    logic host_capability_enable_q, host_capability_enable_d;
    logic packet_processing_disable_q, packet_processing_disable_d;
    ubd_ppmode_t ppmode_q, ppmode_d;
    logic [7:0] tblptr_q, tblptr_d;
    logic [7:0] token_q, token_d;
    logic token_stb_q, token_stb_d;
    logic [7:0] xstat_q, xstat_d;
    logic [UBD_INT_W-1:0] istat_q, istat_d;
    logic [UBD_INT_W-1:0] imask_q, imask_d;
    logic [15:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic se0_q, se0_d;
    logic [31:0] odd_q;
    logic [1:0] pins_s;
    logic wr_ctl;
    logic tok_ok;
    logic setup_evt;
    logic done_ok;
    logic [3:0] done_ep;
    logic [4:0] done_sel;

    ubd_sync #(
        .W(2)
    ) u_sync (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .d({DP_I, DM_I}),
        .q(pins_s)
    );

    // pointers cleared the cycle after the reset bit sets and held even while it stands;
    // a token in that first cycle still sees the old bank
    ubd_pingpong u_pp (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .clear(pingpong_pointer_reset_q),
        .toggle(done_ok),
        .toggle_sel(done_sel),
        .odd_q(odd_q)
    );

    // ==========================================================
    // token acceptance and transfer completion
    assign wr_ctl = WR && (ADDR == UBD_OFS_CONTROL);
    // a disabled or halted engine does not take tokens
    assign tok_ok = TOKEN_VALID && usb_module_enable_q && !packet_processing_disable_q;
    assign setup_evt = tok_ok && TOKEN_SETUP;
    assign done_ok = XFER_DONE && usb_module_enable_q && !pingpong_pointer_reset_q;
    assign done_ep = host_capability_enable_q ? 4'h0 : XFER_EP;
    assign done_sel = {done_ep, XFER_DIR};

    // ==========================================================
    // software registers
    always_comb begin
        usb_module_enable_d = usb_module_enable_q;
        pingpong_pointer_reset_d = pingpong_pointer_reset_q;
        resume_d = resume_q;
        host_capability_enable_d = host_capability_enable_q;
        packet_processing_disable_d = packet_processing_disable_q;
        ppmode_d = ppmode_q;
        tblptr_d = tblptr_q;
        token_d = token_q;
        token_stb_d = 1'b0;
        imask_d = imask_q;
        if (wr_ctl) begin
            usb_module_enable_d = WDATA[UBD_CTL_MODULE_EN];
            pingpong_pointer_reset_d = WDATA[UBD_CTL_PP_RESET];
            resume_d = WDATA[UBD_CTL_RESUME];
            host_capability_enable_d = WDATA[UBD_CTL_HOST_EN];
            packet_processing_disable_d = WDATA[UBD_CTL_PKT_DIS];
        end
        // hardware set wins over a software clear
        if (setup_evt) begin
            packet_processing_disable_d = 1'b1;
        end
        if (WR && ADDR == UBD_OFS_CONFIG1) begin
            ppmode_d = ubd_ppmode_t'(WDATA[1:0]);
        end
        if (WR && ADDR == UBD_OFS_TBL_PTR) begin
            tblptr_d = WDATA[7:0];
        end
        if (WR && ADDR == UBD_OFS_TOKEN) begin
            token_d = WDATA[7:0];
            token_stb_d = 1'b1;
        end
        if (WR && ADDR == UBD_OFS_INT_MASK) begin
            imask_d = WDATA[UBD_INT_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            usb_module_enable_q <= UBD_RST_CONTROL[UBD_CTL_MODULE_EN];
            pingpong_pointer_reset_q <= UBD_RST_CONTROL[UBD_CTL_PP_RESET];
            resume_q <= UBD_RST_CONTROL[UBD_CTL_RESUME];
            host_capability_enable_q <= UBD_RST_CONTROL[UBD_CTL_HOST_EN];
            packet_processing_disable_q <= UBD_RST_CONTROL[UBD_CTL_PKT_DIS];
            ppmode_q <= ubd_ppmode_t'(UBD_RST_PPMODE);
            tblptr_q <= UBD_RST_TBL_PTR;
            token_q <= UBD_RST_TOKEN;
            token_stb_q <= 1'b0;
            imask_q <= UBD_RST_INT;
        end else begin
            usb_module_enable_q <= usb_module_enable_d;
            pingpong_pointer_reset_q <= pingpong_pointer_reset_d;
            resume_q <= resume_d;
            host_capability_enable_q <= host_capability_enable_d;
            packet_processing_disable_q <= packet_processing_disable_d;
            ppmode_q <= ppmode_d;
            tblptr_q <= tblptr_d;
            token_q <= token_d;
            token_stb_q <= token_stb_d;
            imask_q <= imask_d;
        end
    end

    // ==========================================================
    // descriptor lookup
    logic desc_valid_q, desc_valid_d;
    logic [5:0] desc_idx_q, desc_idx_d;
    logic [3:0] tok_ep;

    assign tok_ep = host_capability_enable_q ? 4'h0 : TOKEN_EP;

    always_comb begin
        desc_valid_d = tok_ok;
        desc_idx_d = desc_idx_q;
        if (tok_ok) begin
            desc_idx_d = ubd_bd_index(tok_ep, TOKEN_DIR,
                odd_q[{tok_ep, TOKEN_DIR}], ppmode_q);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            desc_valid_q <= 1'b0;
            desc_idx_q <= 6'h00;
        end else begin
            desc_valid_q <= desc_valid_d;
            desc_idx_q <= desc_idx_d;
        end
    end

    // 512-byte aligned base; 16-bit addresses keep buffers below 64K
    // a 6-bit index keeps the whole table inside 256 bytes
    assign DESC_STAT_ADDR = {tblptr_q[7:1], 1'b0,
        desc_idx_q, 2'b00};
    assign DESC_BUF_ADDR = DESC_STAT_ADDR + UBD_BUF_WORD_OFS;
    assign DESC_INDEX = desc_idx_q;
    assign DESC_VALID = desc_valid_q;

    // ==========================================================
    // transfer status, bus state and interrupts
    logic [3:0] evt;

    always_comb begin
        xstat_d = xstat_q;
        if (done_ok) begin
            // host receive reports the far device's source endpoint
            xstat_d[7:4] = (host_capability_enable_q && !XFER_DIR) ? XFER_SRC_EP
                : (host_capability_enable_q ? token_q[3:0] : XFER_EP);
            xstat_d[UBD_XST_DIR] = XFER_DIR;
            xstat_d[UBD_XST_ODD] = odd_q[done_sel];
        end
        se0_d = !pins_s[1] && !pins_s[0];
        evt = '0;
        evt[UBD_INT_SETUP] = setup_evt;
        evt[UBD_INT_DONE] = done_ok;
        evt[UBD_INT_SE0] = se0_d && !se0_q;
        evt[UBD_INT_REFUSED] = TOKEN_VALID && !tok_ok;
        istat_d = istat_q;
        if (WR && ADDR == UBD_OFS_INT_STAT) begin
            istat_d = istat_q & ~WDATA[UBD_INT_W-1:0];
        end
        istat_d = istat_d | evt;
        irq_d = |(istat_q & imask_q);
        rdata_d = 16'h0000;
        if (RD) begin
            unique case (ADDR)
                UBD_OFS_CONTROL: begin
                    rdata_d[UBD_CTL_MODULE_EN] = usb_module_enable_q;
                    rdata_d[UBD_CTL_PP_RESET] = pingpong_pointer_reset_q;
                    rdata_d[UBD_CTL_RESUME] = resume_q;
                    rdata_d[UBD_CTL_HOST_EN] = host_capability_enable_q;
                    rdata_d[UBD_CTL_PKT_DIS] = packet_processing_disable_q;
                    rdata_d[UBD_CTL_SE0] = se0_q;
                end
                UBD_OFS_CONFIG1: rdata_d[1:0] = ppmode_q;
                UBD_OFS_TBL_PTR: rdata_d[7:0] = tblptr_q;
                UBD_OFS_TOKEN: rdata_d[7:0] = token_q;
                UBD_OFS_XSTAT: rdata_d[7:0] = xstat_q;
                UBD_OFS_INT_STAT: rdata_d[UBD_INT_W-1:0] = istat_q;
                UBD_OFS_INT_MASK: rdata_d[UBD_INT_W-1:0] = imask_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    logic pullup_q, pulldn_q, drv_q;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            xstat_q <= UBD_RST_XSTAT;
            // starts as if SE0 stood, so reset raises no false SE0 edge
            se0_q <= 1'b1;
            istat_q <= UBD_RST_INT;
            irq_q <= 1'b0;
            rdata_q <= 16'h0000;
            pullup_q <= 1'b0;
            pulldn_q <= 1'b0;
            drv_q <= 1'b0;
        end else begin
            xstat_q <= xstat_d;
            se0_q <= se0_d;
            istat_q <= istat_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            pullup_q <= usb_module_enable_d;
            pulldn_q <= host_capability_enable_d;
            drv_q <= resume_d;
        end
    end

    // resume is the K state: D+ low, D- high
    assign DP_O = 1'b0;
    assign DM_O = drv_q;
    assign DP_OE = drv_q;
    assign DM_OE = drv_q;
    assign DP_PULLUP_EN = pullup_q;
    assign DP_PULLDN_EN = pulldn_q;
    assign DM_PULLDN_EN = pulldn_q;
    assign ENGINE_HALT = packet_processing_disable_q;
    assign HOST_TOKEN_STB = token_stb_q;
    assign HOST_TOKEN_PID = token_q[7:4];
    assign HOST_DEST_EP = token_q[3:0];
    assign IRQ = irq_q;
    assign RDATA = rdata_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_setup_taken;
        TOKEN_VALID && TOKEN_SETUP && usb_module_enable_q && !packet_processing_disable_q;
    endsequence

    sequence s_bus_se0;
        !DP_I && !DM_I ##1 (!DP_I && !DM_I) [*3];
    endsequence

    a_packet_processing_disable_on_setup: assert property (
        s_setup_taken |=> packet_processing_disable_q && ENGINE_HALT ##1 !desc_valid_q[*1])
        else $error("setup did not halt the engine");
    a_halt_blocks_desc: assert property (
        (packet_processing_disable_q || !usb_module_enable_q) |=> !DESC_VALID)
        else $error("descriptor issued while halted or disabled");
    a_host_ep0_only: assert property (
        DESC_VALID && $past(host_capability_enable_q) |-> DESC_INDEX < 6'h04)
        else $error("host mode used a non-zero endpoint descriptor");
    a_table_aligned: assert property (
        DESC_VALID |-> DESC_STAT_ADDR[15:9] == tblptr_q[7:1]
            && DESC_STAT_ADDR[8] == 1'b0)
        else $error("descriptor outside the aligned table");
    a_word_pair: assert property (
        DESC_VALID |-> DESC_BUF_ADDR == DESC_STAT_ADDR + 16'h0002
            && DESC_STAT_ADDR[1:0] == 2'h0)
        else $error("descriptor words misplaced");
    a_ppreset_even: assert property (
        wr_ctl && WDATA[UBD_CTL_PP_RESET] |=> ##1 odd_q == 32'h0)
        else $error("ping-pong pointers not returned to even");
    a_se0_live: assert property (
        s_bus_se0 |=> se0_q)
        else $error("single-ended zero not reported");
    a_resume_drive: assert property (
        wr_ctl |=> (DM_OE == $past(WDATA[UBD_CTL_RESUME])
            && (!DM_OE || (DM_O && !DP_O))))
        else $error("resume drive does not follow the control bit");
    a_host_src_ep: assert property (
        XFER_DONE && usb_module_enable_q && !pingpong_pointer_reset_q && host_capability_enable_q && !XFER_DIR
            |=> xstat_q[7:4] == $past(XFER_SRC_EP))
        else $error("host source endpoint not reported");
    a_attach_pins: assert property (
        wr_ctl |=> DP_PULLUP_EN == $past(WDATA[UBD_CTL_MODULE_EN])
            && DM_PULLDN_EN == $past(WDATA[UBD_CTL_HOST_EN]))
        else $error("pull resistors do not follow the control bits");

endmodule

//--- ubd_pkg.sv
package ubd_pkg;

    // ==========================================================
    // register map (byte offsets, 4 apart, on the plain register port)
    localparam logic [7:0] UBD_OFS_CONTROL = 8'h00;
    localparam logic [7:0] UBD_OFS_CONFIG1 = 8'h04;
    localparam logic [7:0] UBD_OFS_TBL_PTR = 8'h08;
    localparam logic [7:0] UBD_OFS_TOKEN = 8'h0C;
    localparam logic [7:0] UBD_OFS_XSTAT = 8'h10;
    localparam logic [7:0] UBD_OFS_INT_STAT = 8'h14;
    localparam logic [7:0] UBD_OFS_INT_MASK = 8'h18;

    // ==========================================================
    // control register fields
    localparam int UBD_CTL_MODULE_EN = 0;
    localparam int UBD_CTL_PP_RESET = 1;
    localparam int UBD_CTL_RESUME = 2;
    localparam int UBD_CTL_HOST_EN = 3;
    localparam int UBD_CTL_PKT_DIS = 5;
    localparam int UBD_CTL_SE0 = 6;

    // transfer status fields
    localparam int UBD_XST_EP_LSB = 4;
    localparam int UBD_XST_DIR = 3;
    localparam int UBD_XST_ODD = 2;

    // interrupt status / mask bits
    localparam int UBD_INT_SETUP = 0;
    localparam int UBD_INT_DONE = 1;
    localparam int UBD_INT_SE0 = 2;
    localparam int UBD_INT_REFUSED = 3;
    localparam int UBD_INT_W = 4;

    // ==========================================================
    // reset values
    localparam logic [15:0] UBD_RST_CONTROL = 16'h0000;
    localparam logic [1:0] UBD_RST_PPMODE = 2'h0;
    localparam logic [7:0] UBD_RST_TBL_PTR = 8'h00;
    localparam logic [7:0] UBD_RST_TOKEN = 8'h00;
    localparam logic [7:0] UBD_RST_XSTAT = 8'h00;
    localparam logic [3:0] UBD_RST_INT = 4'h0;

    // descriptor geometry: two 16-bit words, 64 descriptors
    localparam logic [15:0] UBD_BUF_WORD_OFS = 16'h0002;
    localparam int UBD_DESC_CNT = 64;

    typedef enum logic [1:0] {
        UBD_PP_NONE = 2'h0,
        UBD_PP_EP0_OUT = 2'h1,
        UBD_PP_ALL = 2'h2,
        UBD_PP_ALL_BUT_EP0 = 2'h3
    } ubd_ppmode_t;

    // descriptor index from endpoint, direction (1 = transmit),
    // current odd/even pointer and ping-pong mode
    function automatic logic [5:0] ubd_bd_index(
        input logic [3:0] ep,
        input logic dir,
        input logic odd,
        input ubd_ppmode_t mode
    );
        logic [6:0] v;
        v = 7'h00;
        unique case (mode)
            UBD_PP_NONE: v = {2'b00, ep, dir};
            UBD_PP_EP0_OUT: begin
                if (ep == 4'h0) begin
                    v = dir ? 7'h02 : {6'h00, odd};
                end else begin
                    v = {2'b00, ep, dir} + 7'h01;
                end
            end
            UBD_PP_ALL: v = {1'b0, ep, dir, odd};
            UBD_PP_ALL_BUT_EP0: begin
                if (ep == 4'h0) begin
                    v = {6'h00, dir};
                end else begin
                    v = {1'b0, ep, dir, odd} - 7'h02;
                end
            end
        endcase
        return v[5:0];
    endfunction

endpackage

//--- ubd_sync.sv
`timescale 1ns/100ps

module ubd_sync import ubd_pkg::*; #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // ==========================================================
    // two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

//--- ubd_pingpong.sv
`timescale 1ns/100ps

module ubd_pingpong import ubd_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic toggle,
    input wire logic [4:0] toggle_sel,
    output logic [31:0] odd_q
);

    logic [31:0] odd_d;

    // ==========================================================
    // one odd/even pointer per endpoint and direction
    always_comb begin
        odd_d = odd_q;
        if (clear) begin
            odd_d = '0;
        end else if (toggle) begin
            odd_d[toggle_sel] = ~odd_q[toggle_sel];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            odd_q <= '0;
        end else begin
            odd_q <= odd_d;
        end
    end

endmodule

//--- ubd_far_end.sv
`timescale 1ns/100ps

// ==========================================================
// far party on the bus: a host that keeps its own pull-downs
module ubd_far_end (
    input wire logic dp_o,
    input wire logic dp_oe,
    input wire logic dm_o,
    input wire logic dm_oe,
    input wire logic pullup_en,
    input wire logic se0_cmd,
    output logic dp_i,
    output logic dm_i
);
    // a driving design wins; otherwise se0_cmd or the far pull-downs leave SE0
    // unless the design's D+ pull-up, with se0_cmd low, lifts the line to idle J
    always_comb begin
        if (dp_oe || dm_oe) begin
            dp_i = dp_oe ? dp_o : 1'b0;
            dm_i = dm_oe ? dm_o : 1'b0;
        end else if (se0_cmd || !pullup_en) begin
            dp_i = 1'b0;
            dm_i = 1'b0;
        end else begin
            dp_i = 1'b1;
            dm_i = 1'b0;
        end
    end
endmodule

//--- usb_buffer_descriptor_control_bench.sv
`timescale 1ns/100ps

module usb_buffer_descriptor_control_bench import ubd_pkg::*;;
    // ==========================================================
    // stimulus and observation signals
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, dsa, dba, xstat;
    logic dp_i, dm_i, dp_o, dp_oe, dm_o, dm_oe, pu, pd_p, pd_m;
    logic tv = 1'b0, tdir = 1'b0, tsetup = 1'b0, xd = 1'b0, xdir = 1'b0;
    logic [3:0] tep = 4'h0, xep = 4'h0, xsrc = 4'h0, hpid, hdest;
    logic dv, halt, hstb, irq, se0_cmd = 1'b0, rd_seen = 1'b0;
    logic [5:0] didx;
    logic [31:0] rq[$];
    logic [21:0] dq[$];
    logic [1:0] mode = 2'h0;
    logic [7:0] ptr = 8'h00;
    logic [31:0] odd = 32'h0;
    logic host = 1'b0, dir;
    logic [3:0] ep, tokep = 4'h0;
    int mismatches = 0, n_compared = 0, cycles = 0;

    always #5 clk = ~clk;

    ubd_top dut_u (.SYS_CLK(clk), .RESETN(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DP_I(dp_i),
        .DM_I(dm_i), .DP_O(dp_o), .DP_OE(dp_oe), .DM_O(dm_o),
        .DM_OE(dm_oe), .DP_PULLUP_EN(pu), .DP_PULLDN_EN(pd_p),
        .DM_PULLDN_EN(pd_m), .TOKEN_VALID(tv), .TOKEN_EP(tep),
        .TOKEN_DIR(tdir), .TOKEN_SETUP(tsetup), .XFER_DONE(xd),
        .XFER_EP(xep), .XFER_DIR(xdir), .XFER_SRC_EP(xsrc),
        .DESC_VALID(dv), .DESC_INDEX(didx), .DESC_STAT_ADDR(dsa),
        .DESC_BUF_ADDR(dba), .ENGINE_HALT(halt), .HOST_TOKEN_STB(hstb),
        .HOST_TOKEN_PID(hpid), .HOST_DEST_EP(hdest), .IRQ(irq));

    ubd_far_end far_u (.dp_o(dp_o), .dp_oe(dp_oe), .dm_o(dm_o),
        .dm_oe(dm_oe), .pullup_en(pu), .se0_cmd(se0_cmd), .dp_i(dp_i),
        .dm_i(dm_i));

    // ==========================================================
    // comparison and verdict
    task chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report;
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // generous ceiling: the sequence needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // ==========================================================
    // monitor: oldest note is taken whenever a result shows up
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin : mon
        logic [31:0] r;
        logic [21:0] d;
        if (rd_seen) begin
            r = rq.pop_front();
            chk("read data", rdata & r[31:16], r[15:0]);
        end
        if (dv) begin
            if (dq.size() == 0) begin
                chk("unexpected descriptor", 16'h0001, 16'h0000);
            end else begin
                d = dq.pop_front();
                chk("descriptor index", 16'(didx), 16'(d[21:16]));
                chk("status word addr", dsa, d[15:0]);
                chk("buffer word addr", dba, d[15:0] + 16'h0002);
            end
        end
    end

    // ==========================================================
    // drivers: one-cycle strobes, a free edge between accesses
    task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        rq.push_back({m, e});
        bus(1'b0, a, 16'h0000);
    endtask

    function automatic logic [5:0] eidx(input logic [3:0] e,
        input logic dr, input logic od, input logic [1:0] m);
        case (m)
            2'h0: return {1'b0, e, dr};
            2'h1: return (e == 4'h0) ? (dr ? 6'h02 : {5'h00, od})
                : {1'b0, e, dr} + 6'h01;
            2'h2: return {e, dr, od};
            default: return (e == 4'h0) ? {5'h00, dr} : {e, dr, od} - 6'h02;
        endcase
    endfunction

    task tok(input logic [3:0] e, input logic dr, input logic st,
        input logic acc);
        logic [3:0] u;
        logic [5:0] i;
        u = host ? 4'h0 : e;
        i = eidx(u, dr, odd[{u, dr}], mode);
        if (acc)
            dq.push_back({i, ptr[7:1], 1'b0, i, 2'b00});
        @(posedge clk);
        tv <= 1'b1;
        tep <= e;
        tdir <= dr;
        tsetup <= st;
        @(posedge clk);
        tv <= 1'b0;
        tsetup <= 1'b0;
    endtask

    task xfer(input logic [3:0] e, input logic dr, input logic [3:0] src);
        logic [3:0] u;
        u = host ? 4'h0 : e;
        xstat = {8'h00, host ? (dr ? tokep : src) : e, dr, odd[{u, dr}], 2'b00};
        odd[{u, dr}] = ~odd[{u, dr}];
        @(posedge clk);
        xd <= 1'b1;
        xep <= e;
        xdir <= dr;
        xsrc <= src;
        @(posedge clk);
        xd <= 1'b0;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(78));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        // detached: far pull-downs leave SE0 on the line
        rdc(UBD_OFS_CONTROL, 16'h0040, 16'hFFFF);
        for (int k = 1; k < 9; k++)
            rdc(8'(k * 4), 16'h0000, 16'hFFFF);
        bus(1'b1, UBD_OFS_INT_STAT, 16'h000F);
        ptr = 8'($urandom());
        bus(1'b1, UBD_OFS_TBL_PTR, {8'h00, ptr});
        bus(1'b1, UBD_OFS_CONTROL, 16'h0001);
        repeat (5) @(posedge clk);
        chk("pull-ups", {13'h0000, pu, pd_p, pd_m}, 16'h0004);
        rdc(UBD_OFS_CONTROL, 16'h0001, 16'hFFFF);
        rdc(UBD_OFS_TBL_PTR, {8'h00, ptr}, 16'hFFFF);
        // interrupt: raised, cleared, then masked
        bus(1'b1, UBD_OFS_INT_MASK, 16'h0004);
        se0_cmd <= 1'b1;
        repeat (6) @(posedge clk);
        chk("irq on se0", {15'h0000, irq}, 16'h0001);
        rdc(UBD_OFS_CONTROL, 16'h0041, 16'hFFFF);
        se0_cmd <= 1'b0;
        bus(1'b1, UBD_OFS_INT_STAT, 16'h0004);
        repeat (3) @(posedge clk);
        chk("irq cleared", {15'h0000, irq}, 16'h0000);
        bus(1'b1, UBD_OFS_INT_MASK, 16'h0000);
        se0_cmd <= 1'b1;
        repeat (6) @(posedge clk);
        chk("irq masked", {15'h0000, irq}, 16'h0000);
        rdc(UBD_OFS_INT_STAT, 16'h0004, 16'h0004);
        se0_cmd <= 1'b0;
        bus(1'b1, UBD_OFS_INT_STAT, 16'h000F);
        // every ping-pong mode, both banks, edge endpoints included
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            bus(1'b1, UBD_OFS_CONFIG1, {14'h0000, mode});
            for (int k = 0; k < 6; k++) begin
                ep = (k < 2) ? 4'h0 : (k == 2) ? 4'hF : 4'($urandom_range(15));
                dir = (k < 2) ? k[0] : 1'($urandom());
                tok(ep, dir, 1'b0, 1'b1);
                xfer(ep, dir, 4'h0);
                rdc(UBD_OFS_XSTAT, xstat, 16'hFFFF);
                tok(ep, dir, 1'b0, 1'b1);
            end
        end
        // pointer reset returns the odd bank to even
        // leave the endpoint 2 receive pointer odd so the reset shows
        xfer(4'h2, 1'b0, 4'h0);
        if (!odd[4])
            xfer(4'h2, 1'b0, 4'h0);
        bus(1'b1, UBD_OFS_CONTROL, 16'h0003);
        odd = 32'h0;
        bus(1'b1, UBD_OFS_CONTROL, 16'h0001);
        tok(4'h2, 1'b0, 1'b0, 1'b1);
        // SETUP halts the engine; a halted token is refused
        bus(1'b1, UBD_OFS_INT_MASK, 16'h0001);
        tok(4'h0, 1'b0, 1'b1, 1'b1);
        repeat (2) @(posedge clk);
        chk("halt and irq", {14'h0000, halt, irq}, 16'h0003);
        rdc(UBD_OFS_CONTROL, 16'h0021, 16'hFFFF);
        tok(4'h1, 1'b0, 1'b0, 1'b0);
        rdc(UBD_OFS_INT_STAT, 16'h0009, 16'h0009);
        bus(1'b1, UBD_OFS_CONTROL, 16'h0001);
        bus(1'b1, UBD_OFS_INT_STAT, 16'h000F);
        tok(4'h1, 1'b0, 1'b0, 1'b1);
        chk("halt released", {15'h0000, halt}, 16'h0000);
        // host mode: endpoint 0 descriptors only
        bus(1'b1, UBD_OFS_CONTROL, 16'h0009);
        host = 1'b1;
        repeat (3) @(posedge clk);
        chk("host pulls", {13'h0000, pu, pd_p, pd_m}, 16'h0007);
        tok(4'h7, 1'b1, 1'b0, 1'b1);
        xfer(4'h7, 1'b0, 4'hB);
        rdc(UBD_OFS_XSTAT, xstat, 16'hFFFF);
        bus(1'b1, UBD_OFS_TOKEN, 16'h0095);
        tokep = 4'h5;
        @(negedge clk);
        chk("token fields", {7'h00, hstb, hpid, hdest}, 16'h0195);
        xfer(4'h7, 1'b1, 4'h0);
        rdc(UBD_OFS_XSTAT, xstat, 16'hFFFF);
        // resume drives K; clearing all detaches
        bus(1'b1, UBD_OFS_CONTROL, 16'h000D);
        repeat (3) @(posedge clk);
        chk("resume", 16'({dp_oe, dm_oe, dp_o, dm_o}), 16'h000D);
        bus(1'b1, UBD_OFS_CONTROL, 16'h0000);
        host = 1'b0;
        repeat (3) @(posedge clk);
        chk("detached pulls", 16'({pu, pd_p, pd_m}), 16'h0000);
        chk("drive off", 16'({dp_oe, dm_oe}), 16'h0000);
        repeat (4) @(posedge clk);
        chk("results left", 16'(rq.size() + dq.size()), 16'h0000);
        final_report();
    end
endmodule
